// ===== rtl/sarcs_seq.sv
// SAR conversion sequencer top: start detect, switch order, bit trials, result
`timescale 1ns/1ps
module sarcs_seq #(
   parameter int BITS    = 16,
   parameter int TRIAL_C = 4
) (
   input  wire logic                 clock,
   input  wire logic                 rst_n,
   input  wire logic                 convert_start,
   input  wire sarcs_pkg::sarcs_cmp_s cmp,
   output logic [BITS-1:0]           trial_code,
   output sarcs_pkg::sarcs_sw_s      sw,
   output logic [BITS-1:0]           result,
   output logic                      busy,
   output logic                      done
);
   import sarcs_pkg::*;

   typedef struct packed {
      sarcs_state_e    st;
      logic            start_prev;
      logic [BITS-1:0] code;
      logic [BITS-1:0] mask;
      logic [BITS-1:0] result;
      logic            over;
      logic            under;
      logic            busy;
      logic            done;
      sarcs_sw_s       sw;
   } sarcs_seq_s;

   sarcs_seq_s s_q;
   sarcs_seq_s s_d;
   logic       tick;
   logic       run;

   // ------------------------------------------------------------
   // Conversion clock; runs only during trials
   // ------------------------------------------------------------
   assign run = (s_q.st == SARCS_TRIAL);

   sarcs_tick #(
      .DIV (TRIAL_C)
   ) u_tick (
      .clock (clock),
      .rst_n (rst_n),
      .run   (run),
      .tick  (tick)
   );

   // ------------------------------------------------------------
   // Sequencer
   // ------------------------------------------------------------
   always_comb begin
      s_d            = s_q;
      s_d.start_prev = convert_start;
      s_d.done       = 1'b0;
      unique case (s_q.st)
         SARCS_ACQ: begin
            // Arrays track the input with comparator nodes grounded
            s_d.sw.sample_ground_switch_pos = 1'b1;
            s_d.sw.sample_ground_switch_neg = 1'b1;
            s_d.sw.array_to_input           = 1'b1;
            s_d.sw.core_power               = 1'b0;
            if (convert_start && !s_q.start_prev) begin
               s_d.st   = SARCS_OPEN_SW;
               s_d.busy = 1'b1;
               s_d.sw.sample_ground_switch_pos = 1'b0;
               s_d.sw.sample_ground_switch_neg = 1'b0;
               s_d.sw.core_power               = 1'b1;
            end
         end
         SARCS_OPEN_SW: begin
            // Arrays leave the inputs only after the switches are open
            s_d.st                = SARCS_GROUND;
            s_d.sw.array_to_input = 1'b0;
            s_d.code              = SARCS_CODE_MID;
            s_d.mask              = SARCS_CODE_MID;
         end
         SARCS_GROUND: begin
            // Range flags caught on the held sample before the trials
            s_d.over  = cmp.over;
            s_d.under = cmp.under;
            s_d.st    = SARCS_TRIAL;
         end
         SARCS_TRIAL: begin
            // convert_start is not looked at here at all
            if (tick) begin
               if (!cmp.below) begin
                  s_d.code = s_q.code & ~s_q.mask;
               end
               s_d.mask = s_q.mask >> 1;
               if (s_q.mask[0]) begin
                  s_d.st = SARCS_DONE;
               end else begin
                  s_d.code = s_d.code | (s_q.mask >> 1);
               end
            end
         end
         SARCS_DONE: begin
            // Saturate rather than wrap; plain code otherwise
            if (s_q.over) begin
               s_d.result = SARCS_CODE_FULL;
            end else if (s_q.under) begin
               s_d.result = SARCS_CODE_ZERO;
            end else begin
               s_d.result = s_q.code;
            end
            s_d.st                          = SARCS_ACQ;
            s_d.busy                        = 1'b0;
            s_d.done                        = 1'b1;
            s_d.sw.core_power               = 1'b0;
            s_d.sw.sample_ground_switch_pos = 1'b1;
            s_d.sw.sample_ground_switch_neg = 1'b1;
            s_d.sw.array_to_input           = 1'b1;
         end
      endcase
   end

   // ------------------------------------------------------------
   // State register; reset leaves the core acquiring and powered down
   // ------------------------------------------------------------
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         s_q                             <= '0;
         s_q.st                          <= SARCS_ACQ;
         s_q.start_prev                  <= 1'b1; // no start from a level high at reset
         s_q.sw.sample_ground_switch_pos <= 1'b1;
         s_q.sw.sample_ground_switch_neg <= 1'b1;
         s_q.sw.array_to_input           <= 1'b1;
      end else begin
         s_q <= s_d;
      end
   end

   // Outputs straight from flip-flops
   assign trial_code = s_q.code;
   assign sw         = s_q.sw;
   assign result     = s_q.result;
   assign busy       = s_q.busy;
   assign done       = s_q.done;
endmodule

// ===== rtl/sarcs_pkg.sv
// Package of constants and carrier types for the SAR conversion sequencer
package sarcs_pkg;

   // ------------------------------------------------------------
   // Resolution and codes
   // ------------------------------------------------------------
   localparam int          SARCS_BITS      = 16;
   localparam logic [15:0] SARCS_CODE_ZERO = 16'h0000;
   localparam logic [15:0] SARCS_CODE_FULL = 16'hFFFF;
   localparam logic [15:0] SARCS_CODE_MID  = 16'h8000;

   // ------------------------------------------------------------
   // Timing
   // ------------------------------------------------------------
   localparam int SARCS_CLK_MHZ        = 40;
   localparam int SARCS_SAMPLE_RATE_SPS = 250000;
   // Whole sample period in cycles, rounded down as a longest time
   localparam int SARCS_PERIOD_CYC     = (SARCS_CLK_MHZ * 1000000) / SARCS_SAMPLE_RATE_SPS;
   // Internal conversion clock divider: cycles per bit trial
   localparam int SARCS_TRIAL_CYC      = 4;
   // Cycles the sampling ground switches stay open before arrays are grounded
   localparam int SARCS_SWITCH_CYC     = 1;
   localparam logic [7:0] SARCS_RESET_CNT = 8'h00;

   // ------------------------------------------------------------
   // Types
   // ------------------------------------------------------------
   typedef enum logic [2:0] {
      SARCS_ACQ,
      SARCS_OPEN_SW,
      SARCS_GROUND,
      SARCS_TRIAL,
      SARCS_DONE
   } sarcs_state_e;

   // Switch controls toward the analog array
   typedef struct packed {
      logic sample_ground_switch_pos;
      logic sample_ground_switch_neg;
      logic array_to_input;
      logic core_power;
   } sarcs_sw_s;

   // Comparator observations from the analog front end
   typedef struct packed {
      logic below;    // input not exceeded by trial level
      logic over;     // input above full scale
      logic under;    // input below ground
   } sarcs_cmp_s;

endpackage

// ===== rtl/sarcs_tick.sv
// Internal conversion clock: divides the system clock into trial ticks
`timescale 1ns/1ps
module sarcs_tick #(
   parameter int DIV = 4
) (
   input  wire logic clock,
   input  wire logic rst_n,
   input  wire logic run,
   output logic      tick
);
   import sarcs_pkg::*;

   typedef struct packed {
      logic [7:0] cnt;
      logic       tick;
   } sarcs_tick_s;

   sarcs_tick_s s_q;
   sarcs_tick_s s_d;

   // ------------------------------------------------------------
   // Divider, held at zero when idle so every conversion starts alike
   // ------------------------------------------------------------
   always_comb begin
      s_d      = s_q;
      s_d.tick = 1'b0;
      if (!run) begin
         s_d.cnt = SARCS_RESET_CNT;
      end else if (s_q.cnt == 8'(DIV - 1)) begin
         s_d.cnt  = SARCS_RESET_CNT;
         s_d.tick = 1'b1;
      end else begin
         s_d.cnt = s_q.cnt + 8'h01;
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign tick = s_q.tick;
endmodule

// ===== verif/sarcs_seq_asserts.sv
// Checker of start, switch order, timing and result hold for the sequencer
`timescale 1ns/1ps
module sarcs_seq_asserts #(
   parameter int BITS    = 16,
   parameter int TRIAL_C = 4
) (
   input wire logic                 clock,
   input wire logic                 rst_n,
   input wire logic                 convert_start,
   input wire sarcs_pkg::sarcs_cmp_s cmp,
   input wire logic [BITS-1:0]      trial_code,
   input wire sarcs_pkg::sarcs_sw_s sw,
   input wire logic [BITS-1:0]      result,
   input wire logic                 busy,
   input wire logic                 done
);
   import sarcs_pkg::*;
   // ------------------------------------------------------------
   // Properties
   // ------------------------------------------------------------
   // Busy rise to done: switch setup, range check, a registered tick lead, one tick per bit, the result cycle
   // The busy rise is seen one edge after the start; done is seen one edge after it is set
   localparam int LAT = 4 + BITS * TRIAL_C;
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);
   property p_start;
      $past(rst_n) && !busy && !$past(convert_start) && convert_start |=> busy;
   endproperty
   a_start: assert property (p_start) else $error("start not taken");
   property p_order;
      $rose(busy) |-> !sw.sample_ground_switch_pos && !sw.sample_ground_switch_neg
         && sw.array_to_input ##1 !sw.array_to_input && trial_code == SARCS_CODE_MID;
   endproperty
   a_order: assert property (p_order) else $error("bad switch order");
   property p_lat;
      $rose(busy) |-> ##LAT done;
   endproperty
   a_lat: assert property (p_lat) else $error("bad latency");
   property p_run;
      $fell(busy) |-> done;
   endproperty
   a_run: assert property (p_run) else $error("busy dropped early");
   property p_pulse;
      done |=> !done;
   endproperty
   a_pulse: assert property (p_pulse) else $error("done too long");
   property p_idle;
      done |-> !busy && !sw.core_power && sw.sample_ground_switch_pos
         && sw.sample_ground_switch_neg && sw.array_to_input;
   endproperty
   a_idle: assert property (p_idle) else $error("no power down");
   property p_hold;
      !done |-> $stable(result);
   endproperty
   a_hold: assert property (p_hold) else $error("result moved");
   property p_off;
      !busy |-> !sw.core_power && sw.array_to_input;
   endproperty
   a_off: assert property (p_off) else $error("core on while idle");
   c_conv: cover property ($rose(busy));
   c_full: cover property (done && result == SARCS_CODE_FULL);
   c_zero: cover property (done && result == SARCS_CODE_ZERO);
endmodule
bind sarcs_seq sarcs_seq_asserts #(.BITS(BITS), .TRIAL_C(TRIAL_C)) u_asserts (.clock, .rst_n,
   .convert_start, .cmp, .trial_code, .sw, .result, .busy, .done);

// ===== verif/sarcs_afe_model.sv
// Analog front-end model: comparator and range detect around the trial DAC
`timescale 1ns/1ps
module sarcs_afe_model (
   input  wire logic signed [17:0] vin,
   input  wire logic [15:0]        trial_code,
   output sarcs_pkg::sarcs_cmp_s   cmp
);
   import sarcs_pkg::*;
   // Signed input lets one value stand for over and under range too
   assign cmp.below = $signed({2'b00, trial_code}) <= vin;
   assign cmp.over  = vin > 18'sd65535;
   assign cmp.under = vin < 18'sd0;
endmodule

// ===== verif/test_sarcs_seq.sv
// Self-checking bench: conversions over codes, range clamps and start noise
`timescale 1ns/1ps
module test_sarcs_seq;
   import sarcs_pkg::*;
   logic               clock;
   logic               rst_n;
   logic               convert_start;
   logic signed [17:0] vin;
   sarcs_cmp_s         cmp;
   logic [15:0]        trial_code;
   sarcs_sw_s          sw;
   logic [15:0]        result;
   logic               busy;
   logic               done;
   logic [15:0]        exp_q[$];
   int                 error_cnt;
   int                 compares;
   int                 seed;
   logic signed [17:0] vals[7] = '{0, 32768, 32767, 65535, 1, -5, 70000};
   sarcs_seq dut (.clock, .rst_n, .convert_start, .cmp, .trial_code, .sw, .result, .busy,
      .done);
   sarcs_afe_model afe (.vin, .trial_code, .cmp);
   // ------------------------------------------------------------
   // Tasks
   // ------------------------------------------------------------
   task automatic chk(input string nm, input logic [15:0] s, input logic [15:0] e);
      compares++;
      if (s !== e) begin
         error_cnt++;
         $display("[FAIL] %s exp %h saw %h", nm, e, s);
      end
   endtask
   task automatic results;
      $display("compares %0d errors %0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   // One conversion; a noisy host toggles the start line while busy
   task automatic conv(input logic signed [17:0] v, input logic noisy);
      int n;
      @(posedge clock) #2;
      vin = v;
      convert_start = 1'b1;
      exp_q.push_back(v > 65535 ? SARCS_CODE_FULL : v < 0 ? SARCS_CODE_ZERO : v[15:0]);
      for (n = 0; n < 200 && done !== 1'b1; n++) begin
         @(posedge clock) #2;
         convert_start = n < 60 && (!noisy || $random(seed) % 2 == 0);
      end
      if (n == 200) begin
         error_cnt++;
         results();
      end
   endtask
   // Clock at 40 MHz
   initial begin
      clock = 1'b0;
      forever #12.5 clock = ~clock;
   end
   // Result checker: oldest note against each done pulse
   always @(posedge clock) begin
      if (done === 1'b1) begin
         chk("result", result, exp_q.size() ? exp_q.pop_front() : 16'hXXXX);
      end
   end
   initial begin
      seed = 32'h995d;
      error_cnt = 0;
      compares = 0;
      rst_n = 1'b0;
      convert_start = 1'b0;
      vin = '0;
      repeat (6) @(posedge clock);
      #2 rst_n = 1'b1;
      chk("sw idle", 16'(sw), 16'h000E);
      foreach (vals[i]) conv(vals[i], 1'b0);
      repeat (4) conv($signed({2'b00, 16'($random(seed))}), 1'b1);
      repeat (3) @(posedge clock);
      chk("pending", 16'(exp_q.size()), 16'h0000);
      results();
   end
endmodule
